// File: hw/isd_defines.vh
// Constants for the increment-skip / OR / move instruction decoder
// Notes on behaviour
// RQ1 - Increment-skip adds one, flags unchanged
// RQ2 - Zero sum turns next instruction into no-op
// RQ3 - Destination bit 0 accumulator, 1 register
// RQ4 - Literal OR into accumulator, updates zero
// RQ5 - Register OR to destination, updates zero
// RQ6 - Register copied to accumulator, flags unchanged
// RQ7 - Literal loaded into accumulator, flags unchanged
// RQ8 - Zero flag set when result zero
`ifndef ISD_DEFINES_VH
`define ISD_DEFINES_VH
// ***************
// Opcode patterns
// ***************
`define ISD_OP_INC_SKIP 6'h0F
`define ISD_OP_OR_REG 6'h04
`define ISD_OP_MOVE_REG 6'h08
`define ISD_OP_OR_LIT 6'h1A
`define ISD_OP_LOAD_LIT 6'h19
// ***************
// Field positions and reset values
// ***************
`define ISD_OP_HI 13
`define ISD_OP_LO 8
`define ISD_DEST_BIT 7
`define ISD_ADDR_HI 6
`define ISD_LIT_HI 7
`define ISD_ACC_RESET 8'h00
`define ISD_ZERO_RESET 1'b0
`endif

// File: hw/isd_decode.v
// Opcode decode for the five supported instructions
`timescale 1ns/100ps
`include "isd_defines.vh"
module isd_decode (
   input wire [13:0] instr,
   output wire inc_skip,
   output wire or_reg,
   output wire move_reg,
   output wire or_lit,
   output wire load_lit
);
   wire [5:0] op;
   assign op = instr[`ISD_OP_HI:`ISD_OP_LO];
   assign inc_skip = (op == `ISD_OP_INC_SKIP); // RQ1
   assign or_reg = (op == `ISD_OP_OR_REG); // RQ5
   // Bit 7 set under this opcode is a different move and is ignored here
   assign move_reg = (op == `ISD_OP_MOVE_REG) && !instr[`ISD_DEST_BIT]; // RQ6
   assign or_lit = (op == `ISD_OP_OR_LIT); // RQ4
   assign load_lit = (op == `ISD_OP_LOAD_LIT); // RQ7
endmodule // isd_decode

// File: hw/isd_core.v
// Execute stage for increment-skip, OR and move instructions
`timescale 1ns/100ps
`include "isd_defines.vh"
module isd_core (
   input wire clk,
   input wire rst_n,
   input wire instr_valid,
   input wire [13:0] instr,
   input wire [7:0] reg_rdata,
   output wire [6:0] reg_addr,
   output reg reg_we,
   output reg [6:0] reg_waddr,
   output reg [7:0] reg_wdata,
   output reg [7:0] acc,
   output reg zero_flag,
   output reg skip_active,
   output wire ready
);
   // ***************
   // Decode
   // ***************
   wire inc_skip;
   wire or_reg;
   wire move_reg;
   wire or_lit;
   wire load_lit;
   wire [7:0] lit;
   wire dest_reg;
   wire [8:0] inc_full;
   wire [7:0] inc_sum;
   wire [7:0] or_reg_res;
   wire [7:0] or_lit_res;
   wire exec;
   // Zero test shared by every flag-updating instruction
   function is_zero;
      input [7:0] value;
      begin
         is_zero = (value == 8'h00);
      end
   endfunction
   isd_decode u_dec (
      .instr(instr),
      .inc_skip(inc_skip),
      .or_reg(or_reg),
      .move_reg(move_reg),
      .or_lit(or_lit),
      .load_lit(load_lit)
   );
   assign reg_addr = instr[`ISD_ADDR_HI:0];
   assign lit = instr[`ISD_LIT_HI:0];
   assign dest_reg = instr[`ISD_DEST_BIT];
   // Carry is dropped on purpose so 8'hFF wraps to zero
   assign inc_full = {1'b0, reg_rdata} + 9'h001; // RQ1
   assign inc_sum = inc_full[7:0];
   assign or_reg_res = acc | reg_rdata;
   assign or_lit_res = acc | lit;
   // An instruction arriving during the skip slot is squashed to a no-op
   assign exec = instr_valid && !skip_active; // RQ2
   assign ready = 1'b1;
   // ***************
   // Execute
   // ***************
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= `ISD_ACC_RESET;
         zero_flag <= `ISD_ZERO_RESET;
         skip_active <= 1'b0;
         reg_we <= 1'b0;
         reg_waddr <= 7'h00;
         reg_wdata <= 8'h00;
      end else begin
         reg_we <= 1'b0;
         if (instr_valid && skip_active) begin
            skip_active <= 1'b0; // RQ2
         end else if (exec) begin
            if (inc_skip) begin
               skip_active <= is_zero(inc_sum); // RQ2
               if (dest_reg) begin // RQ3
                  reg_we <= 1'b1;
                  reg_waddr <= reg_addr;
                  reg_wdata <= inc_sum;
               end else begin
                  acc <= inc_sum;
               end
            end else if (or_reg) begin
               zero_flag <= is_zero(or_reg_res); // RQ8
               if (dest_reg) begin // RQ3
                  reg_we <= 1'b1;
                  reg_waddr <= reg_addr;
                  reg_wdata <= or_reg_res; // RQ5
               end else begin
                  acc <= or_reg_res; // RQ5
               end
            end else if (or_lit) begin
               acc <= or_lit_res; // RQ4
               zero_flag <= is_zero(or_lit_res); // RQ8
            end else if (move_reg) begin
               acc <= reg_rdata; // RQ6
            end else if (load_lit) begin
               acc <= lit; // RQ7
            end
         end
      end
   end
endmodule // isd_core

// File: bench/isd_monitor.sv
// Checker for the instruction core
`timescale 1ns/100ps
module isd_monitor(input clk,rst_n,instr_valid,reg_we,zero_flag,skip_active,
   input [13:0] instr,input [6:0] reg_waddr,input [7:0] reg_rdata,reg_wdata,acc);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // A squashed slot must not count as a taken instruction
   wire v=instr_valid&!skip_active;
   wire [5:0] op=instr[13:8];
   sequence sq_skip; skip_active&&instr_valid; endsequence
   inc_flag_a: assert property(v&&op==6'h0F|=>$stable(zero_flag)) else $error("a1");
   inc_wr_a: assert property(v&&op==6'h0F&&instr[7]|=>reg_we&&reg_wdata==$past(reg_rdata)+8'h01)
      else $error("a2");
   skip_arm_a: assert property(v&&op==6'h0F&&reg_rdata==8'hFF|=>skip_active) else $error("a3");
   skip_nop_a: assert property(sq_skip|=>!skip_active&&!reg_we&&$stable(acc)) else $error("a4");
   or_lit_a: assert property(v&&op==6'h1A|=>acc==($past(acc)|$past(instr[7:0])))
      else $error("a5");
   or_reg_a: assert property(v&&op==6'h04&&!instr[7]|=>acc==($past(acc)|$past(reg_rdata)))
      else $error("a6");
   or_zero_a: assert property(v&&op==6'h04|=>
      zero_flag==(($past(instr[7])?reg_wdata:acc)==8'h00)) else $error("a7");
   lit_zero_a: assert property(v&&op==6'h1A|=>zero_flag==(acc==8'h00)) else $error("a10");
   or_waddr_a: assert property(v&&op==6'h04&&instr[7]|=>reg_we&&reg_waddr==$past(instr[6:0]))
      else $error("a11");
   move_a: assert property(v&&op==6'h08&&!instr[7]|=>acc==$past(reg_rdata)) else $error("a8");
   load_a: assert property(v&&op==6'h19|=>acc==$past(instr[7:0])&&$stable(zero_flag))
      else $error("a9");
endmodule // isd_monitor
bind isd_core isd_monitor isd_monitor_inst(.clk,.rst_n,.instr_valid,.reg_we,.zero_flag,
   .skip_active,.instr,.reg_waddr,.reg_rdata,.reg_wdata,.acc);

// File: bench/isd_core_tb_top.sv
// Bench for the instruction core
`timescale 1ns/100ps
module isd_core_tb_top;
   reg clk=0,rst_n=0,instr_valid=0;
   reg [13:0] instr=14'h0000;
   reg [7:0] reg_rdata=8'h00;
   wire [7:0] reg_wdata,acc;
   wire reg_we,zero_flag,skip_active,ready;
   wire [6:0] reg_addr,reg_waddr;
   integer failures=0,compares=0,cyc=0;
   always #20 clk=~clk;
   isd_core isd_core_inst(.clk,.rst_n,.instr_valid,.instr,.reg_rdata,.reg_addr,.reg_we,
      .reg_waddr,.reg_wdata,.acc,.zero_flag,.skip_active,.ready);
   task chk(input [7:0] g,e); begin
      compares=compares+1;
      if (g!==e) begin
         failures=failures+1;
         $display("[FAIL] %0t %h %h",$time,g,e);
      end
   end endtask
   // One instruction per call; results are settled one falling edge later
   task ex(input [13:0] i,input [7:0] r); begin
      @(negedge clk);
      {instr,reg_rdata,instr_valid}={i,r,1'h1};
      @(negedge clk);
      instr_valid=0;
   end endtask
   task summarize; begin
      $display("failures %0d compares %0d",failures,compares);
      if (failures==0&&compares>0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   end endtask
   always @(posedge clk) begin
      cyc=cyc+1;
      if (cyc==500) begin
         failures=failures+1;
         summarize;
      end
   end
   task t_lit; begin
      ex(14'h199A,0); chk(acc,8'h9A);
      ex(14'h1A35,0); chk(acc,8'hBF);
      ex(14'h1900,0); ex(14'h1A00,0); chk(zero_flag,8'h01);
   end endtask
   task t_reg; begin
      ex(14'h1991,0); ex(14'h0413,8'h13); chk(acc,8'h93);
      ex(14'h0493,0); chk({reg_we,reg_wdata[6:0]},8'h93);
      chk({1'b0,reg_waddr},8'h13);
      chk({ready,reg_addr},8'h93);
      ex(14'h0805,0); chk({zero_flag,acc[6:0]},0);
      ex(14'h0885,8'h55); chk(acc,0);
   end endtask
   task t_skip; begin
      ex(14'h0F85,8'hFF); chk({skip_active,zero_flag,reg_wdata[5:0]},8'h80);
      ex(14'h1977,0); chk({skip_active,acc[6:0]},0);
      ex(14'h0F05,8'h10); chk(acc,8'h11);
   end endtask
   initial begin
      repeat (8) @(negedge clk);
      rst_n=1;
      t_lit;
      t_reg;
      t_skip;
      summarize;
   end
endmodule // isd_core_tb_top
